// >>> design/cic_pkg.sv
// constants, state type and a priority helper for the cascaded interrupt controller
// assumes one 20 MHz core clock and an 8-bit i/o port bus in that domain
package cic_pkg;

  // ----------------------------------------------------------------
  // i/o port map
  // ----------------------------------------------------------------
  localparam logic [15:0] PORT_MST_CMD = 16'h0020;
  localparam logic [15:0] PORT_MST_DATA = 16'h0021;
  localparam logic [15:0] PORT_SLV_CMD = 16'h00a0;
  localparam logic [15:0] PORT_SLV_DATA = 16'h00a1;
  localparam logic [15:0] PORT_NMI_MASK = 16'h0070;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int CMD_INIT_BIT = 4;
  localparam int CMD_SEL_BIT = 3;
  localparam int NMI_MASK_BIT = 7;
  localparam int RD_REQ_BIT = 1;
  localparam int RD_SVC_BIT = 0;
  localparam int SMM_EN_BIT = 6;
  localparam int SMM_VAL_BIT = 5;
  localparam logic [2:0] EOI_NONSPEC = 3'h1;
  localparam logic [2:0] EOI_SPEC = 3'h3;

  // ----------------------------------------------------------------
  // reset values and fixed levels
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAVE_ID_RST = 8'h07;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [2:0] CASCADE_LVL = 3'h2;
  localparam logic [2:0] SPURIOUS_LVL = 3'h7;
  localparam logic [15:0] SYNC_RST = 16'h8000;
  localparam logic NMI_MASK_RST = 1'b1;

  typedef enum logic [1:0] {ST_OPER, ST_BASE, ST_CASC, ST_MODE}
    cic_icw_state_t;

  // index of the highest-priority set bit (bit 0 wins), 8 when none
  function automatic logic [3:0] cic_first_set(input logic [7:0] v);
    logic [3:0] idx;
    idx = 4'h8;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

endpackage

// >>> design/cic_unit.sv
// one programmable interrupt unit: request, in-service and mask registers,
// priority resolver and command word decoding
// assumes requests, writes and acknowledges are already in the core domain
module cic_unit
  import cic_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // request levels
  input wire logic [7:0] i_req,
  // port writes
  input wire logic i_wr_even,
  input wire logic i_wr_odd,
  input wire logic [7:0] i_wdata,
  // acknowledge
  input wire logic i_ack_first,
  // outputs
  output logic o_int,
  output logic [7:0] o_vec,
  output logic [7:0] o_status,
  output logic [7:0] o_mask,
  output logic [7:0] o_id,
  output logic [2:0] o_win
);

  logic [7:0] pend_ff, insv_ff, lmask_ff, prev_ff, id_ff;
  logic [7:0] nxt_pend, nxt_insv, nxt_lmask, nxt_prev, nxt_id;
  logic [4:0] base_ff, nxt_base;
  logic [2:0] lvl_ff, nxt_lvl;
  logic smm_ff, nxt_smm, ris_ff, nxt_ris;
  cic_icw_state_t state_ff, nxt_state;
  logic [3:0] req_pri, svc_pri, top_insv;
  logic [7:0] rise, clr_pend, set_insv, clr_insv;

  // ----------------------------------------------------------------
  // priority resolver
  // ----------------------------------------------------------------
  // special mask mode lets a masked in-service level stop blocking
  always_comb
  begin
    req_pri = cic_first_set(pend_ff & ~lmask_ff); // RULE_03
    top_insv = cic_first_set(insv_ff);
    svc_pri = cic_first_set(smm_ff ? (insv_ff & ~lmask_ff) : insv_ff);
    o_int = (req_pri < svc_pri); // RULE_05
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    rise = i_req & ~prev_ff;
    clr_pend = 8'h00;
    set_insv = 8'h00;
    clr_insv = 8'h00;
    nxt_prev = i_req;
    nxt_state = state_ff;
    nxt_lmask = lmask_ff;
    nxt_base = base_ff;
    nxt_id = id_ff;
    nxt_smm = smm_ff;
    nxt_ris = ris_ff;
    nxt_lvl = lvl_ff;
    // first acknowledge strobes the winner into in-service
    if (i_ack_first)
    begin
      if (o_int)
      begin
        nxt_lvl = req_pri[2:0];
        clr_pend[req_pri[2:0]] = 1'b1; // RULE_04
        set_insv[req_pri[2:0]] = 1'b1; // RULE_04
      end
      else
        nxt_lvl = SPURIOUS_LVL;
    end
    if (i_wr_even && i_wdata[CMD_INIT_BIT])
    begin
      nxt_state = ST_BASE; // RULE_22
      nxt_lmask = 8'h00; // RULE_15
      clr_insv = 8'hff; // RULE_15
      clr_pend = 8'hff; // RULE_17
      nxt_id = SLAVE_ID_RST; // RULE_16
      nxt_smm = 1'b0; // RULE_16
      nxt_ris = 1'b0; // RULE_16
    end
    else if (i_wr_even && !i_wdata[CMD_SEL_BIT])
    begin
      nxt_state = ST_OPER; // RULE_19
      case (i_wdata[7:5])
        EOI_NONSPEC:
        begin
          if (!top_insv[3])
            clr_insv[top_insv[2:0]] = 1'b1;
        end
        EOI_SPEC: clr_insv[i_wdata[2:0]] = 1'b1;
        default: clr_insv = 8'h00;
      endcase
    end
    else if (i_wr_even)
    begin
      nxt_state = ST_OPER; // RULE_20
      if (i_wdata[RD_REQ_BIT])
        nxt_ris = i_wdata[RD_SVC_BIT];
      if (i_wdata[SMM_EN_BIT])
        nxt_smm = i_wdata[SMM_VAL_BIT];
    end
    else if (i_wr_odd)
    begin
      case (state_ff)
        ST_BASE:
        begin
          nxt_base = i_wdata[7:3];
          nxt_state = ST_CASC; // RULE_14
        end
        ST_CASC:
        begin
          nxt_id = i_wdata;
          nxt_state = ST_MODE; // RULE_14
        end
        ST_MODE: nxt_state = ST_OPER; // RULE_14
        ST_OPER: nxt_lmask = i_wdata; // RULE_18
        default: nxt_state = ST_OPER;
      endcase
    end
    // a new edge wins over any clear in the same cycle
    nxt_pend = (pend_ff & ~clr_pend & i_req) | rise; // RULE_02
    nxt_insv = (insv_ff & ~clr_insv) | set_insv; // RULE_02
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pend_ff <= 8'h00;
      insv_ff <= 8'h00;
      lmask_ff <= MASK_RST;
      prev_ff <= 8'h00;
      id_ff <= SLAVE_ID_RST;
      base_ff <= 5'h00;
      lvl_ff <= SPURIOUS_LVL;
      smm_ff <= 1'b0;
      ris_ff <= 1'b0;
      state_ff <= ST_OPER;
    end
    else
    begin
      pend_ff <= nxt_pend;
      insv_ff <= nxt_insv;
      lmask_ff <= nxt_lmask;
      prev_ff <= nxt_prev;
      id_ff <= nxt_id;
      base_ff <= nxt_base;
      lvl_ff <= nxt_lvl;
      smm_ff <= nxt_smm;
      ris_ff <= nxt_ris;
      state_ff <= nxt_state;
    end
  end

  // status reads and vector come straight from registers
  assign o_status = ris_ff ? insv_ff : pend_ff; // RULE_12
  assign o_mask = lmask_ff; // RULE_12
  assign o_vec = {base_ff, lvl_ff}; // RULE_23
  assign o_id = id_ff;
  assign o_win = req_pri[2:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  AST_INIT_CLEARS: assert property ( // RULE_15
    i_wr_even && i_wdata[CMD_INIT_BIT] |=> lmask_ff == 8'h00 &&
    state_ff == ST_BASE && id_ff == SLAVE_ID_RST && !smm_ff && !ris_ff)
    else $error("init word did not reset the unit");
  AST_INIT_ORDER: assert property ( // RULE_14
    state_ff == ST_BASE && i_wr_odd && !i_wr_even
    |=> state_ff == ST_CASC && base_ff == $past(i_wdata[7:3]))
    else $error("init word two not taken as vector base");
  AST_MASK_LOAD: assert property ( // RULE_18
    state_ff == ST_OPER && i_wr_odd && !i_wr_even
    |=> lmask_ff == $past(i_wdata))
    else $error("mask write not loaded");
  AST_MASKED_QUIET: assert property ( // RULE_03
    (pend_ff & ~lmask_ff) == 8'h00 |-> !o_int)
    else $error("interrupt raised with every request masked");
  AST_ACK_SETS_INSV: assert property ( // RULE_04
    i_ack_first && o_int && !i_wr_even
    |=> lvl_ff == $past(req_pri[2:0]) && insv_ff[lvl_ff])
    else $error("acknowledge did not mark winner in service");

endmodule

// >>> design/cic_top.sv
// cascaded pair of interrupt units with port decode, acknowledge sequencing
// and the non-maskable interrupt mask latch
// assumes i/o strobes and acknowledge pulses come from core-clock logic;
// request lines and the channel check line are pins and get synchronised
// Operation
// RULE_01: master at 20h/21h, slave at a0h/a1h
// RULE_02: each unit keeps pending and in-service registers
// RULE_03: per-line masks, lower levels stay unaffected
// RULE_04: first acknowledge marks winning level in service
// RULE_05: interrupt only when request outranks service; host acknowledges
// RULE_06: slave output drives master input two
// RULE_07: order 0,1, slave 8-15, then 3-7
// RULE_08: simultaneous requests served one at a time
// RULE_09: port 70h bit 7 sets nmi mask
// RULE_10: nmi mask latch set after power-on
// RULE_11: parity error or channel check raises nmi
// RULE_12: even port status read, odd port mask
// RULE_13: host starts init writing 11h to even port
// RULE_14: next three odd writes are init words
// RULE_15: init clears mask, service, fixed priority
// RULE_16: init sets id 7, no special mask
// RULE_17: init resets edge sensing
// RULE_18: odd writes after init load the mask
// RULE_19: even write bit4 low picks op word
// RULE_20: op words accepted in any order
// RULE_21: timer counter zero drives master input zero
// RULE_22: even write bit4 high restarts init
// RULE_23: acknowledge returns base plus level vector
module cic_top
  import cic_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // i/o port bus
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rdata_vld,
  // processor interrupt handshake
  input wire logic i_int_ack,
  output logic o_intr,
  output logic [7:0] o_vector,
  output logic o_vector_vld,
  // request pins
  input wire logic i_timer_out,
  input wire logic i_irq_kbd,
  input wire logic [7:3] i_irq_lo,
  input wire logic [15:8] i_irq_hi,
  // non-maskable sources
  input wire logic i_parity_err,
  input wire logic i_iochck_n,
  output logic o_nmi
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 15 is the active-low channel check, so it resets high
  logic [15:0] pins, sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;

  always_comb
  begin
    pins = {i_iochck_n, i_irq_hi, i_irq_lo, i_irq_kbd, i_timer_out};
    nxt_sync1 = pins;
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic mst_wr_even, mst_wr_odd, slv_wr_even, slv_wr_odd, nmi_wr;

  // full 16-bit compare so aliases of the ports stay unmapped
  always_comb
  begin
    mst_wr_even = i_io_wr && (i_io_addr == PORT_MST_CMD); // RULE_01
    mst_wr_odd = i_io_wr && (i_io_addr == PORT_MST_DATA); // RULE_01
    slv_wr_even = i_io_wr && (i_io_addr == PORT_SLV_CMD); // RULE_01
    slv_wr_odd = i_io_wr && (i_io_addr == PORT_SLV_DATA); // RULE_01
    nmi_wr = i_io_wr && (i_io_addr == PORT_NMI_MASK);
  end

  // ----------------------------------------------------------------
  // controller pair
  // ----------------------------------------------------------------
  logic [7:0] mst_req, slv_req;
  logic mst_int, slv_int, mst_ack1, slv_ack1;
  logic [7:0] mst_vec, slv_vec, mst_stat, slv_stat;
  logic [7:0] mst_mask, slv_mask, mst_id, slv_id;
  logic [2:0] mst_win, slv_win;
  logic casc_now;

  // slave's output replaces master input two, so slave levels rank
  // between irq1 and irq3
  always_comb
  begin
    mst_req = {sync2_ff[6:2], 1'b0, sync2_ff[1:0]}; // RULE_21
    mst_req[CASCADE_LVL] = slv_int; // RULE_06
    slv_req = sync2_ff[14:7]; // RULE_07
  end

  cic_unit u_master (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_req(mst_req),
    .i_wr_even(mst_wr_even),
    .i_wr_odd(mst_wr_odd),
    .i_wdata(i_io_wdata),
    .i_ack_first(mst_ack1),
    .o_int(mst_int),
    .o_vec(mst_vec),
    .o_status(mst_stat),
    .o_mask(mst_mask),
    .o_id(mst_id),
    .o_win(mst_win)
  );

  cic_unit u_slave (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_req(slv_req),
    .i_wr_even(slv_wr_even),
    .i_wr_odd(slv_wr_odd),
    .i_wdata(i_io_wdata),
    .i_ack_first(slv_ack1),
    .o_int(slv_int),
    .o_vec(slv_vec),
    .o_status(slv_stat),
    .o_mask(slv_mask),
    .o_id(slv_id),
    .o_win(slv_win)
  );

  // ----------------------------------------------------------------
  // acknowledge sequencing
  // ----------------------------------------------------------------
  logic phase_ff, nxt_phase, casc_ff, nxt_casc;
  logic [7:0] vector_ff, nxt_vector;
  logic vld_ff, nxt_vld;

  // the slave answers only when the master's winner is the input whose
  // cascade bit is set and that matches the slave's identity
  always_comb
  begin
    casc_now = mst_int && mst_id[mst_win] &&
               (slv_id[2:0] == mst_win); // RULE_06
    mst_ack1 = i_int_ack && !phase_ff; // RULE_04
    slv_ack1 = mst_ack1 && casc_now; // RULE_08
    nxt_phase = phase_ff;
    nxt_casc = casc_ff;
    nxt_vector = vector_ff;
    nxt_vld = 1'b0;
    if (i_int_ack && !phase_ff)
    begin
      nxt_phase = 1'b1;
      nxt_casc = casc_now;
    end
    else if (i_int_ack)
    begin
      nxt_phase = 1'b0;
      nxt_vector = casc_ff ? slv_vec : mst_vec; // RULE_23
      nxt_vld = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      phase_ff <= 1'b0;
      casc_ff <= 1'b0;
      vector_ff <= 8'h00;
      vld_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      casc_ff <= nxt_casc;
      vector_ff <= nxt_vector;
      vld_ff <= nxt_vld;
    end
  end

  // interrupt line is a handshake level, taken straight from the master
  assign o_intr = mst_int; // RULE_05
  assign o_vector = vector_ff;
  assign o_vector_vld = vld_ff;

  // ----------------------------------------------------------------
  // port reads
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvld_ff, nxt_rvld;

  // nmi port is write-only and unmapped ports read zero
  always_comb
  begin
    nxt_rvld = i_io_rd;
    nxt_rdata = 8'h00;
    if (i_io_rd)
    begin
      case (i_io_addr)
        PORT_MST_CMD: nxt_rdata = mst_stat; // RULE_12
        PORT_MST_DATA: nxt_rdata = mst_mask; // RULE_12
        PORT_SLV_CMD: nxt_rdata = slv_stat; // RULE_12
        PORT_SLV_DATA: nxt_rdata = slv_mask; // RULE_12
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_ff <= 8'h00;
      rvld_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvld_ff <= nxt_rvld;
    end
  end

  assign o_io_rdata = rdata_ff;
  assign o_io_rdata_vld = rvld_ff;

  // ----------------------------------------------------------------
  // non-maskable interrupt
  // ----------------------------------------------------------------
  logic nmi_mask_ff, nxt_nmi_mask, nmi_ff, nxt_nmi;

  // only bit 7 of the written byte matters; the others are dropped
  always_comb
  begin
    nxt_nmi_mask = nmi_mask_ff;
    if (nmi_wr)
      nxt_nmi_mask = i_io_wdata[NMI_MASK_BIT]; // RULE_09
    nxt_nmi = !nmi_mask_ff &&
              (i_parity_err || !sync2_ff[15]); // RULE_11
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      nmi_mask_ff <= NMI_MASK_RST; // RULE_10
      nmi_ff <= 1'b0;
    end
    else
    begin
      nmi_mask_ff <= nxt_nmi_mask;
      nmi_ff <= nxt_nmi;
    end
  end

  assign o_nmi = nmi_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  AST_NMI_GATED: assert property ( // RULE_10
    nmi_mask_ff |=> !o_nmi)
    else $error("nmi raised while masked");
  AST_NMI_MASK_WRITE: assert property ( // RULE_09
    nmi_wr |=> nmi_mask_ff == $past(i_io_wdata[NMI_MASK_BIT]))
    else $error("nmi mask latch did not follow bit 7");
  AST_NMI_PARITY: assert property ( // RULE_11
    !nmi_mask_ff && i_parity_err |=> o_nmi)
    else $error("parity error did not raise nmi");
  AST_ACK_PAIR: assert property ( // RULE_05
    i_int_ack && phase_ff |=> o_vector_vld ##1 !o_vector_vld)
    else $error("second acknowledge gave no single vector pulse");
  AST_SLAVE_VECTOR: assert property ( // RULE_06
    slv_ack1 ##1 !i_int_ack ##1 i_int_ack
    |=> o_vector_vld && o_vector[7:3] == slv_vec[7:3])
    else $error("cascaded acknowledge did not return slave vector");
  AST_READ_VALID: assert property ( // RULE_12
    i_io_rd |=> o_io_rdata_vld)
    else $error("port read gave no valid pulse");
  AST_CASCADE_WINNER: assert property ( // RULE_06
    slv_ack1 |-> mst_win == CASCADE_LVL)
    else $error("slave acknowledged for a level other than two");

endmodule

// >>> sim/cic_host_model.sv
// host side of the interrupt controller: i/o port cycles and acknowledges
// assumes the bench calls these tasks and owns the core clock
module cic_host_model
(
  // clock
  input wire logic i_core_clk,
  // i/o port bus
  output logic [15:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  input wire logic i_io_rdata_vld,
  // acknowledge
  output logic o_int_ack,
  input wire logic [7:0] i_vector,
  input wire logic i_vector_vld
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial
  begin
    o_io_addr = 16'h0000;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
    o_int_ack = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines show inverted values, so a stale byte never passes
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = 1'b1;
    @(negedge i_core_clk);
    o_io_wr = 1'b0;
    o_io_addr = ~a;
    o_io_wdata = ~d;
  endtask

  // read data stands one cycle, so it is taken at the next falling edge
  task automatic io_read(input logic [15:0] a, output logic [7:0] d,
                         output logic v);
    @(negedge i_core_clk);
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(negedge i_core_clk);
    o_io_rd = 1'b0;
    o_io_addr = ~a;
    d = i_io_rdata;
    v = i_io_rdata_vld;
  endtask

  // two acknowledge pulses with one idle cycle between them
  task automatic ack_pair(output logic [7:0] vec, output logic v);
    @(negedge i_core_clk);
    o_int_ack = 1'b1;
    @(negedge i_core_clk);
    o_int_ack = 1'b0;
    @(negedge i_core_clk);
    o_int_ack = 1'b1;
    @(negedge i_core_clk);
    o_int_ack = 1'b0;
    vec = i_vector;
    v = i_vector_vld;
  endtask

  // full init sequence: first word, then exactly three odd-port words
  task automatic init_unit(input logic [15:0] a, input logic [7:0] base,
                           input logic [7:0] casc);
    io_write(a, 8'h11);
    io_write(a + 16'h0001, base);
    io_write(a + 16'h0001, casc);
    io_write(a + 16'h0001, 8'h01);
  endtask
endmodule

// >>> sim/cic_bench.sv
// self-checking bench for the cascaded interrupt controller
// assumes cic_top from design/ and the host model from sim/
module cic_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_core_clk = 1'b0;
  logic i_nrst;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_rdata_vld;
  logic int_ack;
  logic intr;
  logic [7:0] vector;
  logic vector_vld;
  logic timer_out;
  logic irq_kbd;
  logic [7:3] irq_lo;
  logic [15:8] irq_hi;
  logic parity_err;
  logic iochck_n;
  logic nmi;
  int errors = 0;
  int cmp_count = 0;

  // 20 MHz core clock
  always #25 i_core_clk = ~i_core_clk;

  cic_top i_cic_top (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd),
    .i_io_wdata(io_wdata), .o_io_rdata(io_rdata),
    .o_io_rdata_vld(io_rdata_vld), .i_int_ack(int_ack), .o_intr(intr),
    .o_vector(vector), .o_vector_vld(vector_vld),
    .i_timer_out(timer_out), .i_irq_kbd(irq_kbd), .i_irq_lo(irq_lo),
    .i_irq_hi(irq_hi), .i_parity_err(parity_err),
    .i_iochck_n(iochck_n), .o_nmi(nmi));

  cic_host_model i_cic_host_model (
    .i_core_clk(i_core_clk), .o_io_addr(io_addr), .o_io_wr(io_wr),
    .o_io_rd(io_rd), .o_io_wdata(io_wdata), .i_io_rdata(io_rdata),
    .i_io_rdata_vld(io_rdata_vld), .o_int_ack(int_ack),
    .i_vector(vector), .i_vector_vld(vector_vld));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_cic_host_model.io_write(a, d);
  endtask

  // data and its valid flag are both judged on every read
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    i_cic_host_model.io_read(a, d, v);
    check("read data", d, exp);
    check("read valid", {7'h00, v}, 8'h01);
  endtask

  task automatic ack_chk(input logic [7:0] exp);
    logic [7:0] vec;
    logic v;
    i_cic_host_model.ack_pair(vec, v);
    check("vector", vec, exp);
    check("vector valid", {7'h00, v}, 8'h01);
  endtask

  // a hang counts as a failure
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_nrst = 1'b0;
    timer_out = 1'b0;
    irq_kbd = 1'b0;
    irq_lo = 5'h00;
    irq_hi = 8'h00;
    parity_err = 1'b0;
    iochck_n = 1'b1;
    idle(20);
    i_nrst = 1'b1;
    // reset values, then the nmi latch in both states
    rd_chk(16'h0021, 8'hff);
    rd_chk(16'h00a1, 8'hff);
    parity_err = 1'b1;
    idle(3);
    check("nmi masked", {7'h00, nmi}, 8'h00);
    wr(16'h0070, 8'h00);
    idle(2);
    check("nmi parity", {7'h00, nmi}, 8'h01);
    parity_err = 1'b0;
    iochck_n = 1'b0;
    idle(4);
    check("nmi channel", {7'h00, nmi}, 8'h01);
    wr(16'h0070, 8'h80);
    idle(2);
    check("nmi remasked", {7'h00, nmi}, 8'h00);
    iochck_n = 1'b1;
    // bring both units up; slave hangs on master level two
    i_cic_host_model.init_unit(16'h0020, 8'h08, 8'h04);
    i_cic_host_model.init_unit(16'h00a0, 8'h70, 8'h02);
    rd_chk(16'h0021, 8'h00);
    rd_chk(16'h00a1, 8'h00);
    rd_chk(16'h0022, 8'h00);
    rd_chk(16'h0020, 8'h00);
    // masked keyboard must not hide the lower level three
    wr(16'h0021, 8'h02);
    irq_kbd = 1'b1;
    irq_lo[3] = 1'b1;
    idle(4);
    rd_chk(16'h0020, 8'h0a);
    check("intr lower", {7'h00, intr}, 8'h01);
    ack_chk(8'h0b);
    wr(16'h0020, 8'h0b);
    rd_chk(16'h0020, 8'h08);
    wr(16'h0020, 8'h20);
    wr(16'h0020, 8'h0a);
    rd_chk(16'h0020, 8'h02);
    check("intr masked", {7'h00, intr}, 8'h00);
    wr(16'h0021, 8'h00);
    check("intr unmasked", {7'h00, intr}, 8'h01);
    ack_chk(8'h09);
    wr(16'h0020, 8'h20);
    check("intr held line", {7'h00, intr}, 8'h00);
    irq_kbd = 1'b0;
    irq_lo = 5'h00;
    // three levels together are served strictly by rank
    timer_out = 1'b1;
    irq_hi[12] = 1'b1;
    irq_lo[5] = 1'b1;
    idle(5);
    ack_chk(8'h08);
    check("intr in service", {7'h00, intr}, 8'h00);
    wr(16'h0020, 8'h20);
    ack_chk(8'h74);
    wr(16'h00a0, 8'h0b);
    rd_chk(16'h00a0, 8'h10);
    wr(16'h00a0, 8'h64);
    rd_chk(16'h00a0, 8'h00);
    wr(16'h0020, 8'h20);
    ack_chk(8'h0d);
    wr(16'h0020, 8'h20);
    check("intr drained", {7'h00, intr}, 8'h00);
    timer_out = 1'b0;
    irq_hi = 8'h00;
    irq_lo = 5'h00;
    // acknowledge with nothing pending gives the spurious level
    ack_chk(8'h0f);
    // restart init over a live mask, new vector base
    wr(16'h0021, 8'h55);
    wr(16'h0020, 8'h11);
    rd_chk(16'h0021, 8'h00);
    wr(16'h0021, 8'h40);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h01);
    wr(16'h0021, 8'haa);
    rd_chk(16'h0021, 8'haa);
    wr(16'h0021, 8'h00);
    irq_kbd = 1'b1;
    idle(4);
    ack_chk(8'h41);
    // masked in-service level blocks lower ones until special mask mode
    wr(16'h0021, 8'h02);
    irq_lo[3] = 1'b1;
    idle(4);
    check("intr nested", {7'h00, intr}, 8'h00);
    wr(16'h0020, 8'h68);
    check("intr special mask", {7'h00, intr}, 8'h01);
    ack_chk(8'h43);
    give_verdict();
  end
endmodule
